// file: hdl/ldmdc_params.svh
// Purpose: Offsets, field positions, reset values and bus addresses.
// Assumes: Byte-wide register pointer on the two-wire serial bus.
// Notes:   Included by the top design file and the test bench.
`ifndef LDMDC_PARAMS_SVH
`define LDMDC_PARAMS_SVH

`define LDMDC_OFS_PULSE_DIM     8'h00
`define LDMDC_OFS_ANALOG_DIM    8'h01
`define LDMDC_OFS_CONFIG        8'h02
`define LDMDC_OFS_STATUS        8'h03

`define LDMDC_RST_ANALOG_DIM    8'hff
`define LDMDC_RST_PULSE_DIM     8'h00
`define LDMDC_RST_CONFIG        8'h00

`define LDMDC_CFG_CLOCK_OUT_BIT 6

`define LDMDC_ADDR_STANDALONE   7'h60
`define LDMDC_ADDR_BUS_BASE     7'h60

`define LDMDC_STRAP_WAIT        2'h3

`endif

// file: hdl/ldmdc_pkg.sv
// Purpose: Types shared by the mode and dimming control block.
// Assumes: Constants come from ldmdc_params.svh.
// Notes:   Serial writes travel as one struct.
package ldmdc_pkg;

   typedef enum logic [3:0] {
      LDMDC_SER_IDLE,
      LDMDC_SER_ADDR,
      LDMDC_SER_ACK_ADDR,
      LDMDC_SER_REG,
      LDMDC_SER_ACK_BYTE,
      LDMDC_SER_DATA,
      LDMDC_SER_READ,
      LDMDC_SER_READ_ACK
   } ldmdc_ser_e;

   typedef enum logic [1:0] {
      LDMDC_MODE_WAIT_STRAP,
      LDMDC_MODE_IDLE,
      LDMDC_MODE_RUN
   } ldmdc_mode_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] ptr;
      logic [7:0] data;
   } ldmdc_wr_s;

endpackage

// file: hdl/ldmdc_serial_slave.sv
// Purpose: Two-wire serial slave with a byte register pointer.
// Assumes: Bus lines already pass two flip-flops in the caller.
// Notes:   Data line output is open drain, enable means pull low.
`timescale 1ns/10ps
module ldmdc_serial_slave (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_scl,
   input  wire logic             i_sda,
   input  wire logic [6:0]       i_dev_addr,
   input  wire logic [7:0]       i_rd_data,
   output logic [7:0]            o_rd_ptr,
   output logic                  o_sda_oe,
   output ldmdc_pkg::ldmdc_wr_s  o_wr
);
   import ldmdc_pkg::*;

   ldmdc_ser_e  st,  next_st;
   logic [3:0]  cnt, next_cnt;
   logic [7:0]  sh,  next_sh;
   logic [7:0]  ptr, next_ptr;
   logic        rw,  next_rw;
   logic        oe,  next_oe;
   ldmdc_wr_s   wr,  next_wr;
   logic        scl_q, sda_q;
   logic        rise, fall, start, stop;

   assign rise     = i_scl & ~scl_q;
   assign fall     = ~i_scl & scl_q;
   assign start    = i_scl & scl_q & sda_q & ~i_sda;
   assign stop     = i_scl & scl_q & ~sda_q & i_sda;
   assign o_rd_ptr = ptr;
   assign o_sda_oe = oe;
   assign o_wr     = wr;

   always_comb begin
      next_st  = st;
      next_cnt = cnt;
      next_sh  = sh;
      next_ptr = ptr;
      next_rw  = rw;
      next_oe  = oe;
      next_wr  = '0;
      if (start) begin
         next_st  = LDMDC_SER_ADDR;
         next_cnt = 4'h0;
         next_oe  = 1'b0;
      end else if (stop) begin
         next_st = LDMDC_SER_IDLE;
         next_oe = 1'b0;
      end else begin
         case (st)
            LDMDC_SER_ADDR, LDMDC_SER_REG, LDMDC_SER_DATA: begin
               if (rise) begin
                  next_sh  = {sh[6:0], i_sda};
                  next_cnt = cnt + 4'h1;
               end else if (fall && cnt == 4'h8) begin
                  next_cnt = 4'h0;
                  next_oe  = 1'b1;
                  next_st  = LDMDC_SER_ACK_BYTE;
                  if (st == LDMDC_SER_ADDR) begin
                     if (sh[7:1] == i_dev_addr) begin
                        next_rw = sh[0];
                        next_st = LDMDC_SER_ACK_ADDR;
                     end else begin
                        next_oe = 1'b0;
                        next_st = LDMDC_SER_IDLE;
                     end
                  end else if (st == LDMDC_SER_REG) begin
                     next_ptr = sh;
                  end else begin
                     next_wr  = '{valid: 1'b1, ptr: ptr, data: sh};
                     next_ptr = ptr + 8'h01;
                  end
               end
            end
            LDMDC_SER_ACK_ADDR: begin
               if (fall) begin
                  if (rw) begin
                     next_sh = i_rd_data;
                     next_oe = ~i_rd_data[7];
                     next_st = LDMDC_SER_READ;
                  end else begin
                     next_oe = 1'b0;
                     next_st = LDMDC_SER_REG;
                  end
               end
            end
            LDMDC_SER_ACK_BYTE: begin
               if (fall) begin
                  next_oe = 1'b0;
                  next_st = LDMDC_SER_DATA;
               end
            end
            LDMDC_SER_READ: begin
               if (fall) begin
                  next_cnt = cnt + 4'h1;
                  next_sh  = {sh[6:0], 1'b0};
                  next_oe  = ~sh[6];
                  if (cnt == 4'h7) begin
                     next_oe  = 1'b0;
                     next_ptr = ptr + 8'h01;
                     next_st  = LDMDC_SER_READ_ACK;
                  end
               end
            end
            LDMDC_SER_READ_ACK: begin
               if (rise) begin
                  next_rw = ~i_sda;
               end else if (fall) begin
                  next_cnt = 4'h0;
                  next_sh  = i_rd_data;
                  next_oe  = rw & ~i_rd_data[7];
                  next_st  = rw ? LDMDC_SER_READ : LDMDC_SER_IDLE;
               end
            end
            default: begin
               next_st = LDMDC_SER_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st    <= LDMDC_SER_IDLE;
         cnt   <= 4'h0;
         sh    <= 8'h00;
         ptr   <= 8'h00;
         rw    <= 1'b0;
         oe    <= 1'b0;
         wr    <= '0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         st    <= next_st;
         cnt   <= next_cnt;
         sh    <= next_sh;
         ptr   <= next_ptr;
         rw    <= next_rw;
         oe    <= next_oe;
         wr    <= next_wr;
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end

endmodule // ldmdc_serial_slave

// file: hdl/ldmdc_top.sv
// Purpose: Mode select, start-up, analog dimming level and clock output.
// Assumes: Serial bus and pins are asynchronous to i_clk.
//          Straps are held stable from reset onward.
// Notes:   Switching clock copy runs in the oscillator domain.
//          Straps are captured four cycles after reset.
//          Run state is sticky until reset.
`timescale 1ns/10ps
`include "ldmdc_params.svh"
module ldmdc_top (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_osc_clk,
   input  wire logic       i_scl,
   input  wire logic       i_sda_i,
   output logic            o_sda_o,
   output logic            o_sda_oe,
   input  wire logic       i_address_select_pin_one,
   input  wire logic       i_address_select_pin_two,
   input  wire logic       i_pulse_dim_pin,
   output logic            o_serial_mode,
   output logic            o_switching_enable,
   output logic [7:0]      o_channel1_analog_dim_level,
   output logic [8:0]      o_dim_scale_num,
   output logic            o_sync_clock_pin_o,
   output logic            o_sync_clock_pin_oe
);
   import ldmdc_pkg::*;

   logic [1:0]  scl_s, sda_s, pin_s, a1_s, a2_s;
   logic        pin_q, next_pin_q;
   logic [6:0]  dev_addr;
   logic [7:0]  rd_ptr, rd_data;
   ldmdc_wr_s   wr;
   logic        wr_pulse, wr_level, wr_config;

   ldmdc_mode_e mode_st, next_mode_st;
   logic [1:0]  wait_cnt, next_wait_cnt;
   logic        ser_mode, next_ser_mode;
   logic [1:0]  addr_pins, next_addr_pins;
   logic [7:0]  pulse_dim, next_pulse_dim;
   logic [7:0]  dim_level, next_dim_level;
   logic [7:0]  config_reg, next_config_reg;
   logic [8:0]  scale, next_scale;

   logic [1:0]  osc_rst_s, osc_en_s;
   logic        clk_q, next_clk_q;
   logic        out_q, next_out_q;
   logic        oe_q, next_oe_q;

   // Two flip-flops on every pin and bus line
   always_ff @(posedge i_clk) begin
      scl_s <= {scl_s[0], i_scl};
      sda_s <= {sda_s[0], i_sda_i};
      pin_s <= {pin_s[0], i_pulse_dim_pin};
      a1_s  <= {a1_s[0], i_address_select_pin_one};
      a2_s  <= {a2_s[0], i_address_select_pin_two};
   end

   // Bus address fixed when standalone
   assign dev_addr = ser_mode ?
                     (`LDMDC_ADDR_BUS_BASE | {5'h00, addr_pins}) :
                     `LDMDC_ADDR_STANDALONE;

   ldmdc_serial_slave ldmdc_serial_slave_inst (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_scl      (scl_s[1]),
      .i_sda      (sda_s[1]),
      .i_dev_addr (dev_addr),
      .i_rd_data  (rd_data),
      .o_rd_ptr   (rd_ptr),
      .o_sda_oe   (o_sda_oe),
      .o_wr       (wr)
   );

   // Open drain: data line only pulled low
   assign o_sda_o = 1'b0;

   // Read mux, pulse register hidden when standalone
   always_comb begin
      case (rd_ptr)
         `LDMDC_OFS_PULSE_DIM:  rd_data = ser_mode ? pulse_dim : 8'h00;
         `LDMDC_OFS_ANALOG_DIM: rd_data = dim_level;
         `LDMDC_OFS_CONFIG:     rd_data = config_reg;
         `LDMDC_OFS_STATUS:
            rd_data = {6'h00, ser_mode, mode_st == LDMDC_MODE_RUN};
         default:               rd_data = 8'h00;
      endcase
   end

   // Write strobes decoded from the slave's byte struct
   always_comb begin
      wr_pulse  = wr.valid && (wr.ptr == `LDMDC_OFS_PULSE_DIM);
      wr_level  = wr.valid && (wr.ptr == `LDMDC_OFS_ANALOG_DIM);
      wr_config = wr.valid && (wr.ptr == `LDMDC_OFS_CONFIG);
   end

   // Register group
   always_comb begin
      next_pulse_dim  = pulse_dim;
      next_dim_level  = dim_level;
      next_config_reg = config_reg;
      next_scale      = {1'b0, dim_level} + 9'h001;
      if (wr_pulse && ser_mode) begin
         next_pulse_dim = wr.data;
      end
      if (wr_level) begin
         next_dim_level = wr.data;
      end
      if (wr_config) begin
         next_config_reg = wr.data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pulse_dim  <= `LDMDC_RST_PULSE_DIM;
         dim_level  <= `LDMDC_RST_ANALOG_DIM;
         config_reg <= `LDMDC_RST_CONFIG;
         scale      <= 9'h100;
      end else begin
         pulse_dim  <= next_pulse_dim;
         dim_level  <= next_dim_level;
         config_reg <= next_config_reg;
         scale      <= next_scale;
      end
   end

   // Mode group: strap capture, then idle until a start event
   always_comb begin
      next_mode_st   = mode_st;
      next_wait_cnt  = wait_cnt;
      next_ser_mode  = ser_mode;
      next_addr_pins = addr_pins;
      next_pin_q     = (mode_st == LDMDC_MODE_WAIT_STRAP) ? 1'b1 : pin_s[1];
      case (mode_st)
         LDMDC_MODE_WAIT_STRAP: begin
            next_wait_cnt = wait_cnt + 2'h1;
            if (wait_cnt == `LDMDC_STRAP_WAIT) begin
               next_ser_mode  = a1_s[1] | a2_s[1];
               next_addr_pins = {a2_s[1], a1_s[1]};
               next_mode_st   = LDMDC_MODE_IDLE;
            end
         end
         LDMDC_MODE_IDLE: begin
            if (ser_mode) begin
               if (wr_pulse) begin
                  next_mode_st = LDMDC_MODE_RUN;
               end
            end else if (pin_s[1] && !pin_q) begin
               next_mode_st = LDMDC_MODE_RUN;
            end
         end
         LDMDC_MODE_RUN: next_mode_st = LDMDC_MODE_RUN;
         default:        next_mode_st = LDMDC_MODE_WAIT_STRAP;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode_st   <= LDMDC_MODE_WAIT_STRAP;
         wait_cnt  <= 2'h0;
         ser_mode  <= 1'b0;
         addr_pins <= 2'h0;
         pin_q     <= 1'b1;
      end else begin
         mode_st   <= next_mode_st;
         wait_cnt  <= next_wait_cnt;
         ser_mode  <= next_ser_mode;
         addr_pins <= next_addr_pins;
         pin_q     <= next_pin_q;
      end
   end

   // Outputs
   assign o_serial_mode               = ser_mode;
   assign o_switching_enable          = (mode_st == LDMDC_MODE_RUN);
   assign o_channel1_analog_dim_level = dim_level;
   assign o_dim_scale_num             = scale;

   // Oscillator domain: reset and enable cross as levels
   always_ff @(posedge i_osc_clk) begin
      osc_rst_s <= {osc_rst_s[0], i_rst};
      osc_en_s  <= {osc_en_s[0], config_reg[`LDMDC_CFG_CLOCK_OUT_BIT]};
   end

   // Switching clock is the oscillator halved
   always_comb begin
      next_clk_q = ~clk_q;
      next_out_q = osc_en_s[1] & ~clk_q;
      next_oe_q  = osc_en_s[1];
   end

   // Sync pin drive, reset through its synchroniser
   always_ff @(posedge i_osc_clk) begin
      if (osc_rst_s[1]) begin
         clk_q <= 1'b0;
         out_q <= 1'b0;
         oe_q  <= 1'b0;
      end else begin
         clk_q <= next_clk_q;
         out_q <= next_out_q;
         oe_q  <= next_oe_q;
      end
   end

   assign o_sync_clock_pin_o  = out_q;
   assign o_sync_clock_pin_oe = oe_q;

endmodule // ldmdc_top

// file: dv/ldmdc_top_chk.sv
// Purpose: Port assertions for the mode and dimming control.
// Assumes: Straps held stable from reset onward.
// Notes:   Bound to ldmdc_top below.
`timescale 1ns/10ps
module ldmdc_top_chk (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_osc_clk,
   input wire logic       i_scl,
   input wire logic       i_sda_i,
   input wire logic       o_sda_o,
   input wire logic       o_sda_oe,
   input wire logic       i_address_select_pin_one,
   input wire logic       i_address_select_pin_two,
   input wire logic       i_pulse_dim_pin,
   input wire logic       o_serial_mode,
   input wire logic       o_switching_enable,
   input wire logic [7:0] o_channel1_analog_dim_level,
   input wire logic [8:0] o_dim_scale_num,
   input wire logic       o_sync_clock_pin_o,
   input wire logic       o_sync_clock_pin_oe
);
   logic [3:0] age = 4'h0;
   logic [3:0] next_age;
   assign next_age = i_rst ? 4'h0 : age + {3'h0, age != 4'hf};
   always_ff @(posedge i_clk) age <= next_age;

   a_level_reset: assert property (@(posedge i_clk)
      i_rst |=> o_channel1_analog_dim_level == 8'hff)
      else $error("level not full after reset");
   a_scale_follows: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(o_channel1_analog_dim_level) |=> o_dim_scale_num ==
      {1'b0, $past(o_channel1_analog_dim_level)} + 9'h1)
      else $error("scale not level plus one");
   a_level_acked: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(o_channel1_analog_dim_level) |-> ##[0:4] o_sda_oe)
      else $error("level changed outside a write");
   a_mode_strap: assert property (@(posedge i_clk) disable iff (i_rst)
      age == 4'he |-> o_serial_mode ==
      (i_address_select_pin_one | i_address_select_pin_two))
      else $error("mode does not follow straps");
   a_bus_start_acked: assert property (@(posedge i_clk)
      disable iff (i_rst)
      o_serial_mode && $rose(o_switching_enable) |-> ##[0:4] o_sda_oe)
      else $error("bus mode left idle without write");
   a_alone_waits: assert property (@(posedge i_clk) disable iff (i_rst)
      (!o_serial_mode && !i_pulse_dim_pin) [*8] |=> !$rose(o_switching_enable))
      else $error("standalone start without edge");
   a_alone_starts: assert property (@(posedge i_clk) disable iff (i_rst)
      age == 4'hf && !o_serial_mode && $rose(i_pulse_dim_pin)
      |-> ##[1:6] o_switching_enable)
      else $error("standalone edge did not start");
   a_clock_out_off: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(i_rst) |-> !o_sync_clock_pin_oe [*8])
      else $error("clock output on after reset");
   a_clock_toggles: assert property (@(posedge i_osc_clk)
      disable iff (i_rst)
      o_sync_clock_pin_oe && $past(o_sync_clock_pin_oe)
      |-> o_sync_clock_pin_o != $past(o_sync_clock_pin_o))
      else $error("clock output not toggling");
endmodule // ldmdc_top_chk

bind ldmdc_top ldmdc_top_chk ldmdc_top_chk_inst (.*);

// file: dv/ldmdc_host.sv
// Purpose: Host model on the two-wire serial bus.
// Assumes: Data line has a pull-up; host only pulls low.
// Notes:   Each clock phase lasts six or more clocks.
`timescale 1ns/10ps
module ldmdc_host (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   // Bus idles released: clock high, data line not pulled low
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic start();
      o_sda_low <= 1'b1;
      hold(6);
      o_scl <= 1'b0;
      hold(6);
   endtask
   task automatic stop();
      o_sda_low <= 1'b1;
      hold(6);
      o_scl <= 1'b1;
      hold(6);
      o_sda_low <= 1'b0;
      hold(12);
   endtask
   // Eight bits MSB first, then acknowledge bit
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         o_sda_low <= !d[i];
         hold(6);
         o_scl <= 1'b1;
         hold(8);
         q[i] = i_sda;
         o_scl <= 1'b0;
         hold(6);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                     output logic ack);
      logic [8:0] q0, q1, q2;
      start();
      xfer({a, 1'b0, 1'b1}, q0);
      xfer({p, 1'b1}, q1);
      xfer({d, 1'b1}, q2);
      stop();
      ack = !q0[0] && !q1[0] && !q2[0];
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] p,
                     output logic [7:0] d);
      logic [8:0] q;
      start();
      xfer({a, 1'b0, 1'b1}, q);
      xfer({p, 1'b1}, q);
      o_sda_low <= 1'b0;
      hold(6);
      o_scl <= 1'b1;
      hold(6);
      start();
      xfer({a, 1'b1, 1'b1}, q);
      xfer(9'h1ff, q);
      stop();
      d = q[8:1];
   endtask
endmodule // ldmdc_host

// file: dv/led_driver_mode_dim_config_test.sv
// Purpose: Self-checking bench for mode and dimming control.
// Assumes: Straps change only while reset is held.
// Notes:   Registers reached through the host model.
`timescale 1ns/10ps
`include "ldmdc_params.svh"
module led_driver_mode_dim_config_test;
   logic       clk, rst, osc, pin1, pin2, pulse, scl, host_low;
   logic       sda_oe, sda_o, ser, run, sync_o, sync_oe, sda, ack;
   logic [7:0] level, d;
   logic [8:0] scale;
   int         err_count, num_checks;
   int         cyc = 0;
   assign sda = !host_low && !(sda_oe && !sda_o);
   ldmdc_top ldmdc_top_inst (.i_clk(clk), .i_rst(rst), .i_osc_clk(osc),
      .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .i_address_select_pin_one(pin1), .i_address_select_pin_two(pin2),
      .i_pulse_dim_pin(pulse), .o_serial_mode(ser),
      .o_switching_enable(run), .o_channel1_analog_dim_level(level),
      .o_dim_scale_num(scale), .o_sync_clock_pin_o(sync_o),
      .o_sync_clock_pin_oe(sync_oe));
   ldmdc_host ldmdc_host_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(host_low));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      #13;
      forever #40 osc = ~osc;
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic p1, p2);
      @(posedge clk);
      rst <= 1'b1;
      pin1 <= p1;
      pin2 <= p2;
      pulse <= 1'b0;
      repeat (32) @(posedge clk);
      rst <= 1'b0;
      repeat (16) @(posedge clk);
      chk(9'(level), 9'h0ff);
      chk(scale, 9'h100);
      chk(9'(sync_oe), 9'h0);
      chk(9'(run), 9'h0);
      chk(9'(ser), 9'(p1 | p2));
   endtask
   task automatic t_serial();
      logic [7:0] vals [3] = '{8'h00, 8'h80, 8'hff};
      logic       prev;
      do_reset(1'b1, 1'b0);
      ldmdc_host_inst.wr(7'h60, `LDMDC_OFS_ANALOG_DIM, 8'h12, ack);
      chk(9'(ack), 9'h0);
      for (int i = 0; i < 3; i++) begin
         ldmdc_host_inst.wr(7'h61, `LDMDC_OFS_ANALOG_DIM, vals[i], ack);
         chk(9'(ack), 9'h1);
         chk(9'(level), 9'(vals[i]));
         chk(scale, 9'(vals[i]) + 9'h1);
         ldmdc_host_inst.rd(7'h61, `LDMDC_OFS_ANALOG_DIM, d);
         chk(9'(d), 9'(vals[i]));
      end
      ldmdc_host_inst.wr(7'h61, `LDMDC_OFS_CONFIG, 8'h40, ack);
      repeat (40) @(posedge clk);
      chk(9'(sync_oe), 9'h1);
      @(negedge osc);
      prev = sync_o;
      @(negedge osc);
      chk(9'(sync_o ^ prev), 9'h1);
      @(posedge clk);
      ldmdc_host_inst.wr(7'h61, `LDMDC_OFS_CONFIG, 8'h00, ack);
      pulse <= 1'b1;
      repeat (40) @(posedge clk);
      chk(9'(sync_oe), 9'h0);
      chk(9'(run), 9'h0);
      ldmdc_host_inst.wr(7'h61, `LDMDC_OFS_PULSE_DIM, 8'h10, ack);
      chk(9'(run), 9'h1);
      ldmdc_host_inst.rd(7'h61, `LDMDC_OFS_PULSE_DIM, d);
      chk(9'(d), 9'h010);
      ldmdc_host_inst.rd(7'h61, `LDMDC_OFS_STATUS, d);
      chk(9'(d), 9'h003);
   endtask
   task automatic t_alone();
      do_reset(1'b0, 1'b0);
      ldmdc_host_inst.wr(7'h61, `LDMDC_OFS_ANALOG_DIM, 8'h33, ack);
      chk(9'(ack), 9'h0);
      ldmdc_host_inst.wr(7'b1100000, `LDMDC_OFS_ANALOG_DIM, 8'h33, ack);
      chk(9'(ack), 9'h1);
      chk(scale, 9'h034);
      ldmdc_host_inst.wr(7'b1100000, `LDMDC_OFS_PULSE_DIM, 8'h5a, ack);
      ldmdc_host_inst.rd(7'b1100000, `LDMDC_OFS_PULSE_DIM, d);
      chk(9'(d), 9'h0);
      chk(9'(run), 9'h0);
      ldmdc_host_inst.wr(7'b1100000, `LDMDC_OFS_CONFIG, 8'h40, ack);
      repeat (40) @(posedge clk);
      chk(9'(sync_oe), 9'h1);
      pulse <= 1'b1;
      repeat (8) @(posedge clk);
      chk(9'(run), 9'h1);
      ldmdc_host_inst.rd(7'b1100000, `LDMDC_OFS_STATUS, d);
      chk(9'(d), 9'h001);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      rst = 1'b1;
      pin1 = 1'b0;
      pin2 = 1'b0;
      pulse = 1'b0;
      err_count = 0;
      num_checks = 0;
      t_serial();
      t_alone();
      print_verdict();
   end
endmodule // led_driver_mode_dim_config_test
